/* bmdr_pkg.sv */
package bmdr_pkg;
   // ---------------------------------------------------------------
   // Opcode layout
   // ---------------------------------------------------------------
   localparam logic [6:0] OP_HI7_BW = 7'h5D;     // 1011101 then size bit
   localparam logic [7:0] OP_HI8_LONG = 8'hB9;   // 10111001
   localparam logic [3:0] OP_LO_REPEAT = 4'h9;   // 1001
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam int SIZE_BIT = 8;
   localparam logic SIZE_WORD = 1'b1;
   // ---------------------------------------------------------------
   // Element sizes and counts
   // ---------------------------------------------------------------
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_WORD = 32'h0000_0002;
   localparam logic [31:0] STEP_LONG = 32'h0000_0004;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] ADDR16_MASK = 16'hFFFF;
   typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} bmdr_size_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_READ = 2'b01, ST_WRITE = 2'b10, ST_DONE = 2'b11}
      bmdr_state_t;
endpackage

/* bmdr_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) Each pass reads source element and writes it to destination address.
// (R2) Pointers drop by 1, 2 or 4 after every transfer.
// (R3) Counter drops by exactly one per transfer, whatever the size.
// (R4) Repeat until the decremented counter reaches zero.
// (R5) One to 65,536 elements per instruction.
// (R6) A starting count of zero moves 65,536 elements.
// (R7) Software keeps pointer and counter registers distinct, non-overlapping.
// (R8) Overlaps: start high; destination may not exceed source by element.
// (R9) Long form: B9, Rs nonzero, 1001; second word 0, r, Rd, 0.
// (R10) Size bit in first byte picks word (1) or byte (0).
// (R11) On completion set overflow; other flags untouched.
// (R12) Pointers are 16 bits in compact mode, 32 bits otherwise.
module bmdr_seq
   import bmdr_pkg::*;
(
   input wire logic CLK,           // Processor clock
   input wire logic NRST,          // Async reset, active low
   input wire logic START,         // Pulse: opcode and operands valid
   input wire logic [15:0] OPW1,   // First instruction word
   input wire logic [15:0] OPW2,   // Second word (long form)
   input wire logic COMPACT,       // Compact address mode
   input wire logic [31:0] SRC_IN, // Source pointer value
   input wire logic [31:0] DST_IN, // Destination pointer value
   input wire logic [15:0] CNT_IN, // Counter register value
   input wire logic [31:0] RDATA,  // Memory read data
   input wire logic MEM_ACK,       // Memory cycle done
   output logic MEM_RD,            // Read request level
   output logic MEM_WR,            // Write request level
   output logic [31:0] MEM_ADDR,   // Memory address
   output logic [31:0] WDATA,      // Write data
   output logic [1:0] MEM_SIZE,    // Element size code
   output logic [31:0] SRC_OUT,    // Updated source pointer
   output logic [31:0] DST_OUT,    // Updated destination pointer
   output logic [15:0] CNT_OUT,    // Updated counter
   output logic BUSY,              // Instruction in progress
   output logic DONE,              // Pulse: finished, write back
   output logic FLAG_V,            // Overflow flag value
   output logic ILLEGAL            // Pulse: opcode rejected
);
   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   function automatic logic [31:0] step_of(input bmdr_size_t s);
      unique case (s)
         SZ_BYTE: step_of = STEP_BYTE;
         SZ_WORD: step_of = STEP_WORD;
         default: step_of = STEP_LONG;
      endcase
   endfunction

   logic is_long;
   logic is_bw;
   logic legal;
   bmdr_size_t dec_size;
   always_comb
   begin
      is_long = OPW1[15:8] == OP_HI8_LONG && OPW1[7:4] != NIB_ZERO
         && OPW1[3:0] == OP_LO_REPEAT && OPW2[15:12] == NIB_ZERO
         && OPW2[7:4] != NIB_ZERO && OPW2[3:0] == NIB_ZERO; // R9
      is_bw = OPW1[15:9] == OP_HI7_BW && OPW1[7:4] != NIB_ZERO
         && OPW1[3:0] == OP_LO_REPEAT;
      legal = is_long || is_bw;
      if (is_long)
         dec_size = SZ_LONG;
      else if (OPW1[SIZE_BIT] == SIZE_WORD)
         dec_size = SZ_WORD; // R10
      else
         dec_size = SZ_BYTE; // R10
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   bmdr_state_t state_q;
   bmdr_size_t size_q;
   logic compact_q;
   logic [31:0] src_q;
   logic [31:0] dst_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [31:0] src_d;
   logic [31:0] dst_d;
   logic last;

   always_comb
   begin
      cnt_d = cnt_q - CNT_ONE; // R3 R6
      src_d = src_q - step_of(size_q); // R2
      dst_d = dst_q - step_of(size_q); // R2
      if (compact_q)
      begin
         src_d[31:16] = CNT_ZERO; // R12
         dst_d[31:16] = CNT_ZERO; // R12
      end
      last = cnt_d == CNT_ZERO; // R4 R5
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         state_q <= ST_IDLE;
      else
         unique case (state_q)
            ST_IDLE: if (START && legal) state_q <= ST_READ;
            ST_READ: if (MEM_ACK) state_q <= ST_WRITE; // R1
            ST_WRITE: if (MEM_ACK) state_q <= last ? ST_DONE : ST_READ; // R4
            ST_DONE: state_q <= ST_IDLE;
         endcase
   end

   // Operand capture; a zero counter wraps so 65,536 elements move
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         size_q <= SZ_BYTE;
         compact_q <= 1'b0;
         src_q <= STEP_BYTE ^ STEP_BYTE;
         dst_q <= STEP_BYTE ^ STEP_BYTE;
         cnt_q <= CNT_ZERO;
      end
      else if (state_q == ST_IDLE && START && legal)
      begin
         size_q <= dec_size;
         compact_q <= COMPACT;
         src_q <= COMPACT ? {16'h0000, SRC_IN[15:0] & ADDR16_MASK} : SRC_IN; // R12
         dst_q <= COMPACT ? {16'h0000, DST_IN[15:0] & ADDR16_MASK} : DST_IN; // R12
         cnt_q <= CNT_IN; // R6
      end
      else if (state_q == ST_WRITE && MEM_ACK)
      begin
         src_q <= src_d; // R2
         dst_q <= dst_d; // R2
         cnt_q <= cnt_d; // R3
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_ADDR <= 32'h0000_0000;
         WDATA <= 32'h0000_0000;
         MEM_SIZE <= SZ_BYTE;
         BUSY <= 1'b0;
      end
      else
      begin
         MEM_RD <= (state_q == ST_IDLE && START && legal)
            || (state_q == ST_WRITE && MEM_ACK && !last)
            || (state_q == ST_READ && !MEM_ACK); // R1
         MEM_WR <= (state_q == ST_READ && MEM_ACK) || (state_q == ST_WRITE && !MEM_ACK); // R1
         if (state_q == ST_IDLE && START && legal)
            MEM_ADDR <= COMPACT ? {16'h0000, SRC_IN[15:0]} : SRC_IN; // R1
         else if (state_q == ST_READ && MEM_ACK)
            MEM_ADDR <= dst_q; // R1
         else if (state_q == ST_WRITE && MEM_ACK)
            MEM_ADDR <= src_d; // R1
         if (state_q == ST_READ && MEM_ACK)
            WDATA <= RDATA;
         if (state_q == ST_IDLE && START && legal)
            MEM_SIZE <= dec_size;
         BUSY <= (state_q == ST_IDLE && START && legal)
            || (state_q != ST_IDLE && state_q != ST_DONE);
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         SRC_OUT <= 32'h0000_0000;
         DST_OUT <= 32'h0000_0000;
         CNT_OUT <= CNT_ZERO;
         DONE <= 1'b0;
         FLAG_V <= 1'b0;
         ILLEGAL <= 1'b0;
      end
      else
      begin
         DONE <= state_q == ST_WRITE && MEM_ACK && last;
         ILLEGAL <= state_q == ST_IDLE && START && !legal;
         if (state_q == ST_WRITE && MEM_ACK)
         begin
            SRC_OUT <= src_d;
            DST_OUT <= dst_d;
            CNT_OUT <= cnt_d;
         end
         // Only V is produced here; the flag file keeps C, Z, S, D, H
         if (state_q == ST_WRITE && MEM_ACK && last)
            FLAG_V <= 1'b1; // R11
         else if (state_q == ST_IDLE && START && legal)
            FLAG_V <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   a_count_step: assert property (state_q == ST_WRITE && MEM_ACK // R3
      |=> cnt_q == $past(cnt_q) - CNT_ONE)
      else $error("counter did not drop by one");
   a_ptr_step: assert property (state_q == ST_WRITE && MEM_ACK && !compact_q // R2
      |=> src_q == $past(src_q) - step_of(size_q))
      else $error("source pointer step wrong");
   a_dst_step: assert property (state_q == ST_WRITE && MEM_ACK && !compact_q // R2
      |=> dst_q == $past(dst_q) - step_of(size_q))
      else $error("destination pointer step wrong");
   a_stop_zero: assert property (DONE |-> CNT_OUT == CNT_ZERO && FLAG_V) // R4
      else $error("finished with nonzero counter");
   a_no_early_stop: assert property (state_q == ST_WRITE && MEM_ACK && cnt_q != CNT_ONE // R4
      |=> state_q == ST_READ)
      else $error("stopped before counter reached zero");
   a_read_then_write: assert property (state_q == ST_READ && MEM_ACK // R1
      |=> MEM_WR && MEM_ADDR == $past(dst_q) && WDATA == $past(RDATA))
      else $error("write does not follow read");
   // Checked on the bus itself, where a wide pointer would actually leak out
   a_compact_ptr: assert property ((MEM_RD || MEM_WR) && compact_q // R12
      |-> MEM_ADDR[31:16] == CNT_ZERO)
      else $error("compact address upper half not zero");
   a_long_decode: assert property (state_q == ST_IDLE && START && is_long // R9
      |=> size_q == SZ_LONG)
      else $error("long form not decoded");
   a_size_bit: assert property (state_q == ST_IDLE && START && is_bw && OPW1[SIZE_BIT] // R10
      |=> size_q == SZ_WORD)
      else $error("word form not decoded");
   a_byte_size: assert property (state_q == ST_IDLE && START && is_bw && !OPW1[SIZE_BIT] // R10
      |=> size_q == SZ_BYTE)
      else $error("byte form not decoded");
   a_v_flag: assert property (DONE |-> FLAG_V) // R11
      else $error("overflow flag not set at completion");

   c_wrap: cover property (state_q == ST_IDLE && START && legal && CNT_IN == CNT_ZERO); // R6
   c_long: cover property (DONE && size_q == SZ_LONG);
   c_single: cover property (state_q == ST_IDLE && START && legal && CNT_IN == CNT_ONE
      ##[4:20] DONE);
endmodule // bmdr_seq
`default_nettype wire

/* bmdr_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bmdr_mem_model
(
   input wire logic clk,         // Processor clock
   input wire logic nrst,        // Async reset, active low
   input wire logic rd,          // Read request
   input wire logic wr,          // Write request
   input wire logic [31:0] addr, // Request address
   input wire logic [3:0] lat,   // Wait cycles before ack
   output logic ack,             // Cycle done
   output logic [31:0] rdata     // Read data
);
   logic [3:0] wait_q;
   logic [31:0] idle_q;
   assign ack = (rd || wr) && (wait_q == lat);
   // Data is derived from the address so the bench can predict it
   assign rdata = (ack && rd) ? (addr ^ 32'h5A5A_C3C3) : idle_q;
   always_ff @(posedge clk or negedge nrst)
      if (!nrst) wait_q <= 4'h0;
      else if (!(rd || wr) || ack) wait_q <= 4'h0;
      else wait_q <= wait_q + 4'h1;
   // Released bus flips every cycle so stale data never looks valid
   always_ff @(posedge clk or negedge nrst)
      if (!nrst) idle_q <= 32'hA5A5_A5A5;
      else idle_q <= ~rdata;
endmodule // bmdr_mem_model
`default_nettype wire

/* block_move_decrement_repeat_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module block_move_decrement_repeat_tb;
   import bmdr_pkg::*;
   logic clk, nrst, start, compact, busy, done, flag_v, illegal, mem_rd, mem_wr, mem_ack;
   logic [15:0] opw1, opw2, cnt_in, cnt_out;
   logic [31:0] src_in, dst_in, rdata, mem_addr, wdata, src_out, dst_out;
   logic [31:0] exp_src, exp_dst, exp_step, mask, am;
   logic [1:0] mem_size;
   logic [3:0] lat;
   bmdr_size_t exp_sz;
   int failures, checks_done, n_xfer;
   bmdr_seq dut (.CLK(clk), .NRST(nrst), .START(start), .OPW1(opw1), .OPW2(opw2),
      .COMPACT(compact), .SRC_IN(src_in), .DST_IN(dst_in), .CNT_IN(cnt_in), .RDATA(rdata),
      .MEM_ACK(mem_ack), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr),
      .WDATA(wdata), .MEM_SIZE(mem_size), .SRC_OUT(src_out), .DST_OUT(dst_out),
      .CNT_OUT(cnt_out), .BUSY(busy), .DONE(done), .FLAG_V(flag_v), .ILLEGAL(illegal));
   bmdr_mem_model mem (.clk(clk), .nrst(nrst), .rd(mem_rd), .wr(mem_wr), .addr(mem_addr),
      .lat(lat), .ack(mem_ack), .rdata(rdata));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Each acked cycle is judged against the walked-down pointers
   always @(posedge clk)
      if (nrst && mem_ack && mem_rd)
      begin
         chk(mem_addr, exp_src);
         chk({30'h0, mem_size}, {30'h0, exp_sz});
      end
      else if (nrst && mem_ack && mem_wr)
      begin
         chk(mem_addr, exp_dst);
         chk(wdata & mask, (exp_src ^ 32'h5A5A_C3C3) & mask);
         n_xfer++;
         exp_src = (exp_src - exp_step) & am;
         exp_dst = (exp_dst - exp_step) & am;
      end
   // ---------------------------------------------------------------
   // Stimulus tasks
   // ---------------------------------------------------------------
   task automatic launch(input logic [15:0] w1, w2, input logic cm, input logic [31:0] s, d,
      input logic [15:0] c, input bmdr_size_t sz);
      am = cm ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      exp_src = s & am;
      exp_dst = d & am;
      exp_sz = sz;
      exp_step = (sz == SZ_BYTE) ? 32'h1 : (sz == SZ_WORD) ? 32'h2 : 32'h4;
      mask = (sz == SZ_BYTE) ? 32'hFF : (sz == SZ_WORD) ? 32'hFFFF : 32'hFFFF_FFFF;
      n_xfer = 0;
      @(negedge clk);
      {opw1, opw2, compact, src_in, dst_in, cnt_in} = {w1, w2, cm, s, d, c};
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
   endtask
   task automatic run(input logic [15:0] w1, w2, input logic cm, input logic [31:0] s, d,
      input logic [15:0] c, input bmdr_size_t sz, input int n);
      int i;
      launch(w1, w2, cm, s, d, c, sz);
      for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk);
      if (i == 2000)
      begin
         failures++;
         summarize();
      end
      chk(src_out, exp_src);
      chk(dst_out, exp_dst);
      chk({16'h0, cnt_out}, 32'h0);
      chk({31'h0, flag_v}, 32'h1);
      chk(n_xfer, n);
      $display("transfer test done: %0d elements", n);
   endtask
   task automatic t_illegal;
      logic [15:0] bad1 [2] = '{16'hBB09, 16'hB929};
      logic [15:0] bad2 [2] = '{16'h0310, 16'h0300};
      int seen;
      for (int k = 0; k < 2; k++)
      begin
         launch(bad1[k], bad2[k], 1'b0, 32'h100, 32'h80, 16'h2, SZ_WORD);
         seen = 0;
         repeat (3)
         begin
            seen += illegal;
            chk({31'h0, mem_rd | busy}, 32'h0);
            @(negedge clk);
         end
         chk(seen, 1);
         chk({31'h0, flag_v}, 32'h1);
      end
      $display("illegal opcode test done");
   endtask
   task automatic t_reset_mid;
      int i;
      lat = 4'h2;
      launch(16'hBA29, 16'h0310, 1'b0, 32'h0002_0000, 32'h0001_0000, 16'h0000, SZ_BYTE);
      for (i = 0; i < 200 && n_xfer < 3; i++) @(negedge clk);
      if (i == 200)
      begin
         failures++;
         summarize();
      end
      @(negedge clk);
      chk({16'h0, cnt_out}, 32'h0000_FFFD);
      chk({30'h0, busy, flag_v}, 32'h2);
      nrst = 1'b0;
      @(negedge clk);
      chk({29'h0, busy, mem_rd, done}, 32'h0);
      nrst = 1'b1;
      @(negedge clk);
      $display("zero count and reset test done");
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {nrst, start, compact, opw1, opw2, src_in, dst_in, cnt_in, lat} = '0;
      failures = 0;
      checks_done = 0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      run(16'hBA29, 16'h0310, 1'b0, 32'h0001_0107, 32'h0000_8107, 16'h3, SZ_BYTE, 3);
      lat = 4'h1;
      run(16'hBA29, 16'h0310, 1'b0, 32'h40, 32'h20, 16'h1, SZ_BYTE, 1);
      lat = 4'h0;
      run(16'hBB29, 16'h0310, 1'b1, 32'h7777_404A, 32'h1111_202A, 16'h6, SZ_WORD, 6);
      chk(src_out, 32'h0000_403E);
      chk(dst_out, 32'h0000_201E);
      lat = 4'h3;
      run(16'hB929, 16'h0310, 1'b0, 32'h8000_0010, 32'h4000_0020, 16'h4, SZ_LONG, 4);
      t_illegal();
      t_reset_mid();
      run(16'hBA29, 16'h0310, 1'b0, 32'h40, 32'h20, 16'h2, SZ_BYTE, 2);
      summarize();
   end
endmodule // block_move_decrement_repeat_tb
`default_nettype wire
